// *** inc/scb_pkg.sv ***
// constants, field layout and state types of the synthesizer control word bank
`default_nettype none

package scb_pkg;

    localparam int WORD_W = 32;
    localparam int SEL_W = 3;
    localparam int NUM_REGS = 5;
    localparam logic [WORD_W-1:0] WORD_RESET = 32'h0000_0000;

    // selector codes
    localparam logic [SEL_W-1:0] SEL_WHOLE = 3'h0;
    localparam logic [SEL_W-1:0] SEL_LOWER = 3'h1;
    localparam logic [SEL_W-1:0] SEL_REFDIV = 3'h2;
    localparam logic [SEL_W-1:0] SEL_FUNC = 3'h3;
    localparam logic [SEL_W-1:0] SEL_BLEED = 3'h4;

    // whole and upper fraction word
    localparam int MON_LSB = 27;
    localparam int MON_W = 4;
    localparam int WHOLE_LSB = 15;
    localparam int WHOLE_W = 12;
    localparam int FINE_DIVISOR_NUMERATOR_HI_LSB = 3;
    localparam int FINE_DIVISOR_NUMERATOR_HI_W = 12;
    // lower fraction word
    localparam int FINE_DIVISOR_NUMERATOR_LO_LSB = 15;
    localparam int FINE_DIVISOR_NUMERATOR_LO_W = 13;
    // reference divider word
    localparam int SLIP_BIT = 28;
    localparam int PUMP_LSB = 24;
    localparam int PUMP_W = 4;
    localparam int PRESC_BIT = 22;
    localparam int HALV_BIT = 21;
    localparam int DOUB_BIT = 20;
    localparam int RCNT_LSB = 15;
    localparam int RCNT_W = 5;
    // function word
    localparam int SDRST_BIT = 14;
    localparam int LDP_BIT = 7;
    localparam int POL_BIT = 6;
    localparam int PD_BIT = 5;
    localparam int TRI_BIT = 4;
    localparam int CRST_BIT = 3;
    // bleed and fastlock word
    localparam int BLEED_LSB = 23;
    localparam int BLEED_W = 2;
    localparam int CLKMODE_LSB = 19;
    localparam int CLKMODE_W = 2;
    localparam int FLT_LSB = 7;
    localparam int FLT_W = 12;

    localparam logic [BLEED_W-1:0] BLEED_ON = 2'h3;
    localparam logic [CLKMODE_W-1:0] MODE_FASTLOCK = 2'h1;
    localparam logic [MON_W-1:0] MON_FASTLOCK = 4'hC;

    // lock detect run lengths in comparison cycles
    localparam int LOCK_SHORT = 24;
    localparam int LOCK_LONG = 40;
    localparam int LOCK_CNT_W = 6;

    typedef enum logic [1:0] {
        SCB_FL_IDLE = 2'b01,
        SCB_FL_WIDE = 2'b10
    } scb_fl_state_t;

endpackage : scb_pkg

`default_nettype wire

// *** design/scb_shift.sv ***
// serial input shift register with latch strobe capture
`default_nettype none

module scb_shift (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // serial link
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic latch_strobe,
    // captured word
    output logic [scb_pkg::WORD_W-1:0] word,
    output logic word_valid
);

    logic ser_clk_q;
    logic latch_q;
    logic [scb_pkg::WORD_W-1:0] sreg;

    ////////////////////////////////////////////////////////////////
    // edge history; link pins are synchronous to clk_sys
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ser_clk_q <= 1'b0;
            latch_q <= 1'b0;
        end else begin
            ser_clk_q <= ser_clk;
            latch_q <= latch_strobe;
        end
    end

    // msb first, newest bit lands at bit 0
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sreg <= scb_pkg::WORD_RESET;
        end else if (ser_clk && !ser_clk_q) begin
            sreg <= {sreg[scb_pkg::WORD_W-2:0], ser_data};
        end
    end

    // a bit shifted in the strobe cycle itself is not part of the word
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            word <= scb_pkg::WORD_RESET;
            word_valid <= 1'b0;
        end else begin
            word_valid <= latch_strobe && !latch_q;
            if (latch_strobe && !latch_q) begin
                word <= sreg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_shift_msb_first: assert property ((ser_clk && !ser_clk_q) |=> sreg[0] == $past(ser_data))
        else $error("serial bit not shifted in");
    a_latch_copy: assert property ((latch_strobe && !latch_q) |=> word_valid && word == $past(sreg))
        else $error("latch did not copy shift word");

endmodule : scb_shift

`default_nettype wire

// *** design/scb_lock.sv ***
// digital lock detect: run of consecutive in-window comparison cycles
`default_nettype none

module scb_lock #(
    parameter int SHORT_RUN = scb_pkg::LOCK_SHORT,
    parameter int LONG_RUN = scb_pkg::LOCK_LONG
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // comparison side
    input wire logic tick,
    input wire logic in_window,
    input wire logic long_sel,
    input wire logic clear,
    // status
    output logic locked
);

    localparam logic [scb_pkg::LOCK_CNT_W-1:0] SHORT_N = scb_pkg::LOCK_CNT_W'(SHORT_RUN);
    localparam logic [scb_pkg::LOCK_CNT_W-1:0] LONG_N = scb_pkg::LOCK_CNT_W'(LONG_RUN);

    logic [scb_pkg::LOCK_CNT_W-1:0] run;
    logic [scb_pkg::LOCK_CNT_W-1:0] target;

    assign target = long_sel ? LONG_N : SHORT_N;

    ////////////////////////////////////////////////////////////////
    // one miss restarts the run; run saturates at target
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            run <= '0;
            locked <= 1'b0;
        end else if (clear) begin
            run <= '0;
            locked <= 1'b0;
        end else if (tick) begin
            if (!in_window) begin
                run <= '0;
                locked <= 1'b0;
            end else if (run < target) begin
                run <= run + 1'b1;
                locked <= (run + 1'b1) >= target;
            end else begin
                locked <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_lock_run_len: assert property ($rose(locked) |-> $past(run) == target - 1'b1)
        else $error("lock asserted at wrong run length");
    a_lock_miss: assert property ((tick && !in_window) |=> !locked)
        else $error("lock held after a miss");
    c_lock_long: cover property (long_sel && $rose(locked));

endmodule : scb_lock

`default_nettype wire

// *** design/scb_bank.sv ***
// control word bank: five write-only words, reference path, fastlock timer
`default_nettype none

module scb_bank (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // serial programming link
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic latch_strobe,
    // reference and phase comparator side
    input wire logic comparison_source_input,
    input wire logic phase_in_window,
    // divisor settings
    output logic [scb_pkg::WHOLE_W-1:0] whole_divisor,
    output logic [scb_pkg::FINE_DIVISOR_NUMERATOR_HI_W+scb_pkg::FINE_DIVISOR_NUMERATOR_LO_W-1:0] fine_divisor_numerator,
    output logic prescaler_select,
    output logic modulator_reset,
    // reference path settings and comparison clock
    output logic [scb_pkg::RCNT_W-1:0] reference_count,
    output logic reference_doubler_enable,
    output logic reference_halver_enable,
    output logic comparison_tick,
    output logic comparison_half,
    // charge pump
    output logic [scb_pkg::PUMP_W-1:0] pump_current_code,
    output logic slip_assist_enable,
    output logic pump_three_state,
    output logic negative_bleed_on,
    // function controls and status
    output logic phase_polarity,
    output logic software_powerdown,
    output logic counters_held,
    output logic lock_window_precision,
    output logic lock_detect,
    // monitor and fastlock
    output logic [scb_pkg::MON_W-1:0] monitor_select,
    output logic fastlock_enabled,
    output logic [scb_pkg::FLT_W-1:0] fastlock_timer,
    output logic wideband_active,
    output logic fastlock_switch_closed
);

    localparam int RC_W = scb_pkg::RCNT_W + 1;

    logic [scb_pkg::WORD_W-1:0] word;
    logic word_valid;
    logic [scb_pkg::SEL_W-1:0] sel;
    logic [scb_pkg::WORD_W-1:0] shadow [scb_pkg::NUM_REGS];
    logic whole_wr;

    // double-buffered active copies
    logic [scb_pkg::FINE_DIVISOR_NUMERATOR_LO_W-1:0] fine_divisor_numerator_lo_act;
    logic [scb_pkg::RCNT_W-1:0] rcnt_act;
    logic doub_act;
    logic halv_act;
    logic [scb_pkg::PUMP_W-1:0] pump_act;

    // reference path state
    logic ref_q;
    logic ref_edge;
    logic [RC_W-1:0] ref_cnt;
    logic [RC_W-1:0] ratio;
    logic r_pulse;
    logic half_q;
    logic hold;

    // fastlock state
    scb_pkg::scb_fl_state_t fl_state;
    scb_pkg::scb_fl_state_t next_fl_state;
    logic [scb_pkg::FLT_W-1:0] fl_cnt;

    ////////////////////////////////////////////////////////////////
    // serial front end keeps running in power-down
    scb_shift u_shift (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ser_clk(ser_clk),
        .ser_data(ser_data),
        .latch_strobe(latch_strobe),
        .word(word),
        .word_valid(word_valid)
    );

    assign sel = word[scb_pkg::SEL_W-1:0];
    assign whole_wr = word_valid && (sel == scb_pkg::SEL_WHOLE);

    ////////////////////////////////////////////////////////////////
    // one shadow word per selector; codes 5..7 land nowhere
    for (genvar i = 0; i < scb_pkg::NUM_REGS; i++) begin : g_bank
        always_ff @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
                shadow[i] <= scb_pkg::WORD_RESET;
            end else if (word_valid && (sel == scb_pkg::SEL_W'(i))) begin
                shadow[i] <= word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // buffered settings move to the active side only on a selector-000 write
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fine_divisor_numerator_lo_act <= '0;
            rcnt_act <= '0;
            doub_act <= 1'b0;
            halv_act <= 1'b0;
            pump_act <= '0;
        end else if (whole_wr) begin
            fine_divisor_numerator_lo_act <= shadow[1][scb_pkg::FINE_DIVISOR_NUMERATOR_LO_LSB +: scb_pkg::FINE_DIVISOR_NUMERATOR_LO_W];
            rcnt_act <= shadow[2][scb_pkg::RCNT_LSB +: scb_pkg::RCNT_W];
            doub_act <= shadow[2][scb_pkg::DOUB_BIT];
            halv_act <= shadow[2][scb_pkg::HALV_BIT];
            pump_act <= shadow[2][scb_pkg::PUMP_LSB +: scb_pkg::PUMP_W];
        end
    end

    // modulator reset pulse follows the write unless the policy bit skips it
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            modulator_reset <= 1'b0;
        end else begin
            modulator_reset <= whole_wr && !shadow[3][scb_pkg::SDRST_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////
    // field views of the stored words
    assign monitor_select = shadow[0][scb_pkg::MON_LSB +: scb_pkg::MON_W];
    assign whole_divisor = shadow[0][scb_pkg::WHOLE_LSB +: scb_pkg::WHOLE_W];
    assign fine_divisor_numerator = {shadow[0][scb_pkg::FINE_DIVISOR_NUMERATOR_HI_LSB +: scb_pkg::FINE_DIVISOR_NUMERATOR_HI_W],
                                     fine_divisor_numerator_lo_act};

    // reference divider word; slip assist and prescaler are not buffered
    assign slip_assist_enable = shadow[2][scb_pkg::SLIP_BIT];
    assign prescaler_select = shadow[2][scb_pkg::PRESC_BIT];
    assign reference_count = rcnt_act;
    assign reference_doubler_enable = doub_act;
    assign reference_halver_enable = halv_act;
    assign pump_current_code = pump_act;

    // function word
    assign lock_window_precision = shadow[3][scb_pkg::LDP_BIT];
    assign phase_polarity = shadow[3][scb_pkg::POL_BIT];
    assign software_powerdown = shadow[3][scb_pkg::PD_BIT];
    assign pump_three_state = shadow[3][scb_pkg::TRI_BIT] || software_powerdown;
    assign hold = shadow[3][scb_pkg::CRST_BIT] || software_powerdown;
    assign counters_held = hold;

    // bleed and fastlock word
    assign negative_bleed_on = shadow[4][scb_pkg::BLEED_LSB +: scb_pkg::BLEED_W] == scb_pkg::BLEED_ON;
    assign fastlock_enabled =
        shadow[4][scb_pkg::CLKMODE_LSB +: scb_pkg::CLKMODE_W] == scb_pkg::MODE_FASTLOCK;
    assign fastlock_timer = shadow[4][scb_pkg::FLT_LSB +: scb_pkg::FLT_W];

    ////////////////////////////////////////////////////////////////
    // active reference edge: falling only, or both with the doubler
    assign ref_edge = doub_act ? (comparison_source_input ^ ref_q)
                               : (ref_q && !comparison_source_input);
    // code zero stands for the top ratio of thirty-two
    assign ratio = (rcnt_act == '0) ? RC_W'(32) : {1'b0, rcnt_act};

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ref_q <= 1'b0;
        end else begin
            ref_q <= comparison_source_input;
        end
    end

    // reference counter, parked at its load state while held
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ref_cnt <= '0;
            r_pulse <= 1'b0;
        end else if (hold) begin
            ref_cnt <= '0;
            r_pulse <= 1'b0;
        end else begin
            r_pulse <= 1'b0;
            if (ref_edge) begin
                if (ref_cnt + 1'b1 >= ratio) begin
                    ref_cnt <= '0;
                    r_pulse <= 1'b1;
                end else begin
                    ref_cnt <= ref_cnt + 1'b1;
                end
            end
        end
    end

    // toggle stage halves the counter output for an even duty cycle
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            half_q <= 1'b0;
            comparison_tick <= 1'b0;
        end else if (hold) begin
            half_q <= 1'b0;
            comparison_tick <= 1'b0;
        end else begin
            if (r_pulse) begin
                half_q <= !half_q;
            end
            comparison_tick <= r_pulse && (!halv_act || half_q);
        end
    end
    assign comparison_half = half_q;

    ////////////////////////////////////////////////////////////////
    // lock detect, cleared whenever the counters are held
    scb_lock #(
        .SHORT_RUN(scb_pkg::LOCK_SHORT),
        .LONG_RUN(scb_pkg::LOCK_LONG)
    ) u_lock (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .tick(comparison_tick),
        .in_window(phase_in_window),
        .long_sel(lock_window_precision),
        .clear(hold),
        .locked(lock_detect)
    );

    ////////////////////////////////////////////////////////////////
    // fastlock: a selector-000 write starts the wideband interval
    always_comb begin
        next_fl_state = fl_state;
        unique case (fl_state)
            scb_pkg::SCB_FL_IDLE: begin
                if (whole_wr && fastlock_enabled && fastlock_timer != '0) begin
                    next_fl_state = scb_pkg::SCB_FL_WIDE;
                end
            end
            scb_pkg::SCB_FL_WIDE: begin
                if (comparison_tick && fl_cnt == 12'h001) begin
                    next_fl_state = scb_pkg::SCB_FL_IDLE;
                end
            end
            default: begin
                next_fl_state = scb_pkg::SCB_FL_IDLE;
            end
        endcase
        if (hold) begin
            next_fl_state = scb_pkg::SCB_FL_IDLE;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fl_state <= scb_pkg::SCB_FL_IDLE;
        end else begin
            fl_state <= next_fl_state;
        end
    end

    // interval counted in comparison periods; a new write restarts it
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fl_cnt <= '0;
        end else if (hold) begin
            fl_cnt <= '0;
        end else if (whole_wr && fastlock_enabled) begin
            fl_cnt <= fastlock_timer;
        end else if (comparison_tick && fl_cnt != '0) begin
            fl_cnt <= fl_cnt - 1'b1;
        end
    end

    assign wideband_active = fl_state == scb_pkg::SCB_FL_WIDE;
    // monitor pin is grounded only with the fastlock switch code selected
    assign fastlock_switch_closed = wideband_active && (monitor_select == scb_pkg::MON_FASTLOCK);

    ////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_upper_fine_divisor_numerator_store: assert property (whole_wr |=> fine_divisor_numerator[24:13] == $past(word[14:3]))
        else $error("upper fraction not stored");
    a_lower_buffered: assert property ((word_valid && sel == scb_pkg::SEL_LOWER) |=> $stable(fine_divisor_numerator))
        else $error("lower fraction took effect early");
    a_lower_applied: assert property (whole_wr |=> fine_divisor_numerator[12:0] == $past(shadow[1][27:15]))
        else $error("lower fraction not joined");
    a_sd_reset: assert property (whole_wr |=> modulator_reset == !$past(shadow[3][14]))
        else $error("modulator reset policy broken");
    a_pd_effects: assert property (software_powerdown |-> pump_three_state && counters_held)
        else $error("power-down effects missing");
    a_held_no_lock: assert property (hold |=> !lock_detect && !comparison_tick)
        else $error("lock or tick while held");
    a_bleed_on: assert property ((word_valid && sel == scb_pkg::SEL_BLEED && word[24:23] == 2'h3) |=> negative_bleed_on)
        else $error("bleed not switched on");
    a_fastlock_start: assert property ((!hold && whole_wr && fastlock_enabled && fastlock_timer != '0)
        |=> wideband_active && fl_cnt == $past(fastlock_timer))
        else $error("fastlock interval did not start");
    // the tick was formed with last cycle's halver setting, so judge it by that
    a_halver_spacing: assert property ((comparison_tick && $past(halv_act)) |-> half_q == 1'b0)
        else $error("halver tick at wrong pulse");
    // a new pump code or ratio must wait for the next selector-000 write
    a_refdiv_buffered: assert property ((word_valid && sel == scb_pkg::SEL_REFDIV && !whole_wr)
        |=> $stable(pump_current_code) && $stable(reference_count))
        else $error("reference settings took effect early");
    // held counters sit at their load state
    a_held_counter: assert property (hold |=> ref_cnt == '0)
        else $error("reference counter ran while held");
    // the last counted comparison period closes the wideband interval
    a_wide_ends: assert property ((wideband_active && comparison_tick && fl_cnt == 12'h001 && !whole_wr)
        |=> !wideband_active)
        else $error("wideband interval overran");
    // switch only closes inside the interval and with the switch code selected
    a_switch_gate: assert property (fastlock_switch_closed |-> wideband_active
        && monitor_select == scb_pkg::MON_FASTLOCK)
        else $error("fastlock switch closed outside interval");
    a_slip_unbuffered: assert property ((word_valid && sel == scb_pkg::SEL_REFDIV) |=> slip_assist_enable == $past(word[28]))
        else $error("slip assist not captured");

    c_whole_write: cover property (whole_wr ##1 modulator_reset);
    c_fastlock_run: cover property (wideband_active ##1 !wideband_active);
    c_lock_seen: cover property ($rose(lock_detect));
    c_powerdown: cover property ($rose(software_powerdown));

endmodule : scb_bank

`default_nettype wire

// *** tb/scb_host.sv ***
// host controller model driving the three-wire programming link
`default_nettype none
module scb_host (
    // clock
    input wire logic clk_sys,
    // serial link
    output logic ser_clk,
    output logic ser_data,
    output logic latch_strobe
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        latch_strobe = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    // one whole word; slow stretches each clock phase
    task send(input logic [31:0] w, input int slow);
        for (int i = 31; i >= 0; i--) begin
            @(posedge clk_sys) #2 ser_data = w[i];
            repeat (1 + slow) @(posedge clk_sys);
            #2 ser_clk = 1'b1;
            repeat (2 + slow) @(posedge clk_sys);
            #2 ser_clk = 1'b0;
        end
        // released data shows the inverse, never a stale bit
        ser_data = ~w[0];
        repeat (2) @(posedge clk_sys);
        #2 latch_strobe = 1'b1;
        repeat (2) @(posedge clk_sys);
        #2 latch_strobe = 1'b0;
    endtask : send
endmodule : scb_host
`default_nettype wire

// *** tb/testbench.sv ***
// self-checking bench for the control word bank
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic ref_in = 1'b0;
    logic win = 1'b0;
    wire ser_clk, ser_data, latch_strobe, tick, lock, mres, wb, fsc;
    wire [72:0] o;
    logic [31:0] w [5] = '{default: 32'h0};
    logic [31:0] mk [8] = '{32'h7FFF_FFF8, 32'h0FFF_8000, 32'h1F7F_8000, 32'h0000_40F8, 32'h019F_FF80,
        32'hFFFF_FFF8, 32'hFFFF_FFF8, 32'hFFFF_FFF8};
    logic [6:0] c [4] = '{7'h01, 7'h20, 7'h45, 7'h63};
    logic [23:0] act = 24'h0;
    logic [7:0] mrc = 8'h0;
    logic [7:0] emr = 8'h0;
    logic [80:0] q [$];
    logic [80:0] meas;
    int miscompares = 0;
    int compares = 0;
    int cyc = 0;
    event wdone, mdone;
    scb_bank dut_u (.clk_sys(clk_sys), .resetn(resetn), .ser_clk(ser_clk), .ser_data(ser_data),
        .latch_strobe(latch_strobe), .comparison_source_input(ref_in), .phase_in_window(win),
        .whole_divisor(o[72:61]), .fine_divisor_numerator(o[60:36]), .prescaler_select(o[35]),
        .modulator_reset(mres), .reference_count(o[34:30]), .reference_doubler_enable(o[29]),
        .reference_halver_enable(o[28]), .comparison_tick(tick), .comparison_half(), .pump_current_code(o[27:24]),
        .slip_assist_enable(o[23]), .pump_three_state(o[22]), .negative_bleed_on(o[21]), .phase_polarity(o[20]),
        .software_powerdown(o[19]), .counters_held(o[18]), .lock_window_precision(o[17]), .lock_detect(lock),
        .monitor_select(o[16:13]), .fastlock_enabled(o[12]), .fastlock_timer(o[11:0]), .wideband_active(wb),
        .fastlock_switch_closed(fsc));
    scb_host host_u (.clk_sys(clk_sys), .ser_clk(ser_clk), .ser_data(ser_data), .latch_strobe(latch_strobe));
    ////////////////////////////////////////////////////////////
    // clock, reference toggling every cycle, pulse count, hang guard
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) #2 ref_in = ~ref_in;
    always @(negedge clk_sys) if (mres === 1'b1) mrc <= mrc + 8'h1;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            stop_test();
        end
    end
    // watchers: oldest note against what appeared
    always @(wdone) chk({mrc, o}, q.pop_front());
    always @(mdone) chk(meas, q.pop_front());
    ////////////////////////////////////////////////////////////
    task chk(input logic [80:0] a, input logic [80:0] e);
        compares++;
        if (a !== e) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, a, e);
        end
    endtask : chk
    task stop_test();
        if (miscompares == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : stop_test
    // settings every output should show, from the words written so far
    function logic [80:0] expv();
        return {emr, w[0][26:15], w[0][14:3], act[23:11], w[2][22], act[10:0], w[2][28], w[3][4] | w[3][5],
            w[4][24:23] == 2'h3, w[3][6], w[3][5], w[3][3] | w[3][5], w[3][7], w[0][30:27],
            w[4][20:19] == 2'h1, w[4][18:7]};
    endfunction : expv
    task wr(input logic [31:0] d);
        host_u.send(d, $urandom_range(2));
        if (d[2:0] < 3'h5) w[d[2:0]] = d;
        if (d[2:0] == 3'h0) begin
            act = {w[1][27:15], w[2][19:15], w[2][20], w[2][21], w[2][27:24]};
            emr = emr + {7'h0, !w[3][14]};
        end
        repeat (3) @(negedge clk_sys);
        q.push_back(expv());
        ->wdone;
    endtask : wr
    task note(input logic [80:0] m, input logic [80:0] e);
        @(negedge clk_sys);
        meas = m;
        q.push_back(e);
        ->mdone;
    endtask : note
    // cycles up to the next comparison tick
    task tk(output int k);
        k = 0;
        do begin
            @(negedge clk_sys);
            k++;
        end while (tick !== 1'b1 && k < 300);
    endtask : tk
    ////////////////////////////////////////////////////////////
    initial begin
        int k, n;
        logic [31:0] d;
        void'($urandom(31));
        repeat (12) @(posedge clk_sys);
        #2 resetn = 1'b1;
        // random words, refused selectors among them
        repeat (40) begin
            @(posedge clk_sys) #2 win = 1'($urandom_range(1));
            k = $urandom_range(7);
            d = ($urandom & mk[k]) | 32'(k);
            if (k == 0) d[26] = 1'b1;
            if (k == 2 && !w[3][6]) d[28] = 1'b0;
            if (k == 3 && w[2][28]) d[6] = 1'b1;
            wr(d);
        end
        // reference path: ratio, doubler, halver
        wr(32'h0000_0003);
        foreach (c[i]) begin
            wr(32'h0040_0002 | {10'h0, c[i], 15'h0});
            wr(32'h0400_0000);
            tk(k);
            tk(k);
            tk(k);
            n = ((c[i][4:0] == 5'h0) ? 32 : c[i][4:0]) * (c[i][5] ? 1 : 2) * (c[i][6] ? 2 : 1);
            note(81'(k), 81'(n));
        end
        // lock run lengths, power-down clearing lock first
        for (int p = 0; p < 2; p++) begin
            wr(32'h0000_0023 | 32'(p) << 7);
            note(81'(lock), 81'h0);
            @(posedge clk_sys) #2 win = 1'b0;
            wr(32'h0000_0003 | 32'(p) << 7);
            @(posedge clk_sys) #2 win = 1'b1;
            n = 0;
            do begin
                tk(k);
                n++;
                @(negedge clk_sys);
            end while (lock !== 1'b1 && n < 60);
            note(81'(n), 81'(p ? scb_pkg::LOCK_LONG : scb_pkg::LOCK_SHORT));
        end
        // fastlock: longest timer, switch code on the monitor select
        wr(32'h000F_FF84);
        wr(32'h6400_0000);
        note(81'({wb, fsc}), 81'h3);
        stop_test();
    end
endmodule : testbench
`default_nettype wire
